// *** hdl/tae_pkg.sv ***
// Overview of operation
// - eight channels, 2-bit mode field bits 0-1
// - mode bits select timer, event, one-shot, PWM; one-shot and PWM never count here
// - timer mode counts f1, f8, f32 or subclock
// - timer mode counts down, reloads on underflow
// - timer underflow rate is source over n+1
// - start flag one counts, zero halts
// - timer mode requests interrupt on underflow
// - reading timer register returns current count
// - write while stopped loads reload and counter
// - write while running loads reload only
// - gate option lets input pin level pause counting
// - pulse output toggles out pin on underflow
// - channels 2,3,4,7 also two-phase; others single; here only flagged, every channel counts single-phase
// - event source is input edge or timer overflow
// - direction from software or out pin level
// - event mode reloads on overflow or underflow
// - up count rate is events over FFFF-n+1
// - down count rate is events over n+1
// - event mode interrupts on overflow and underflow
// - free-run wraps without reloading
// - pulse output toggles on overflow and underflow
package tae_pkg;
    // ==========================================================
    // widths and constants
    localparam int TAE_WIDTH = 16;
    localparam int TAE_CHANNELS = 8;
    localparam logic [15:0] TAE_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TAE_CNT_MIN = 16'h0000;
    localparam logic [15:0] TAE_CNT_RESET = 16'h0000;
    localparam int TAE_MODE_LSB = 0;
    localparam int TAE_MODE_MSB = 1;
    localparam logic [4:0] TAE_DIV8_LAST = 5'h07;
    localparam logic [4:0] TAE_DIV32_LAST = 5'h1F;
    // bit mask of channels with two-phase capability (2,3,4,7)
    localparam logic [7:0] TAE_TWO_PHASE_MASK = 8'h9C;

    // ==========================================================
    // mode field encoding
    typedef enum logic [1:0] {
        TAE_MODE_TIMER = 2'h0,
        TAE_MODE_EVENT = 2'h1,
        TAE_MODE_ONESHOT = 2'h2,
        TAE_MODE_PWM = 2'h3
    } tae_mode_t;

    // internal clock choice in timer mode
    typedef enum logic [1:0] {
        TAE_SRC_DIV1 = 2'h0,
        TAE_SRC_DIV8 = 2'h1,
        TAE_SRC_DIV32 = 2'h2,
        TAE_SRC_SUB32 = 2'h3
    } tae_clk_sel_t;

    // event source choice in event mode
    typedef enum logic [2:0] {
        TAE_EV_PIN = 3'h0,
        TAE_EV_TIMER_TWO = 3'h1,
        TAE_EV_TIMER_FIVE = 3'h2,
        TAE_EV_NEIGHBOR_J = 3'h3,
        TAE_EV_NEIGHBOR_K = 3'h4
    } tae_ev_sel_t;

    // configuration bundle from software
    typedef struct packed {
        logic [7:0] mode_reg;      // bits 1:0 are the mode field
        tae_clk_sel_t clk_sel;
        tae_ev_sel_t ev_sel;
        logic ev_falling;          // 1: count falling edges of the input pin
        logic dir_from_pin;        // 1: direction from out pin level
        logic dir_up_sw;           // software direction, 1 = up
        logic gate_en;
        logic gate_level;          // input level that allows counting
        logic pulse_en;
        logic free_run;
    } tae_cfg_t;

    // overflow strobes from other timers
    typedef struct packed {
        logic input_timer_two;
        logic input_timer_five;
        logic neighbor_timer_j;
        logic neighbor_timer_k;
    } tae_ovf_t;

    // software write port of the timer register
    typedef struct packed {
        logic we;
        logic [15:0] data;
    } tae_wr_t;
endpackage : tae_pkg

// *** hdl/tae_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser with a registered edge detector
module tae_sync (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    import tae_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic s1;     // first stage, seen only by s2
        logic s2;
        logic s3;
    } tae_sync_st_t;

    tae_sync_st_t st_q;
    tae_sync_st_t st_d;

    // next state
    always_comb begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    // registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.s2;
    assign rise_out = st_q.s2 & ~st_q.s3;
    assign fall_out = ~st_q.s2 & st_q.s3;
endmodule : tae_sync
`default_nettype wire

// *** hdl/tae_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
// one 16-bit timer channel in timer or single-phase event counter mode
module tae_timer #(
    parameter int CHANNEL = 0,                 // channel number 0..7
    parameter int WIDTH = tae_pkg::TAE_WIDTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire tae_pkg::tae_cfg_t cfg_in,      // mode and option bits
    input wire logic start_in,                 // count start flag
    input wire tae_pkg::tae_wr_t wr_in,        // timer register write
    input wire logic subclk_div32_in,          // one-cycle subclock tick
    input wire tae_pkg::tae_ovf_t ovf_in,      // overflow strobes of other timers
    input wire logic timer_in_pin_in,          // gate or count input
    input wire logic timer_out_pin_in,         // direction input level
    output logic [WIDTH-1:0] count_out,        // timer register read value
    output logic [WIDTH-1:0] reload_out,       // reload register
    output logic irq_out,                      // one-cycle interrupt request
    output logic timer_out_pin_out,            // pulse output level
    output logic timer_out_pin_oe_out,         // high while driving out pin
    output logic in_pin_busy_out,              // input pin owned by timer
    output logic out_pin_busy_out,             // out pin owned by timer
    output logic two_phase_cap_out,            // channel can count two-phase
    output logic active_out                    // counting is enabled
);
    import tae_pkg::*;

    // ==========================================================
    // channel state
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic [WIDTH-1:0] reload;
        logic [4:0] pre;          // prescaler for clk_div8 and clk_div32
        logic irq;
        logic pout;
        logic pin_oe;
        logic in_busy;
        logic out_busy;
        logic cap;
        logic active;
    } tae_ch_st_t;

    tae_ch_st_t st_q;
    tae_ch_st_t st_d;

    // synchronised pin views
    logic in_level;
    logic in_rise;
    logic in_fall;
    logic dir_level;

    // ==========================================================
    // pin synchronisers
    tae_sync u_sync_in (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(timer_in_pin_in),
        .level_out(in_level),
        .rise_out(in_rise),
        .fall_out(in_fall)
    );

    tae_sync u_sync_dir (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(timer_out_pin_in),
        .level_out(dir_level),
        .rise_out(),
        .fall_out()
    );

    // ==========================================================
    // helpers
    // mode field lives in bits 1:0 of the mode register
    function automatic tae_mode_t mode_of(input logic [7:0] mreg);
        mode_of = tae_mode_t'(mreg[TAE_MODE_MSB:TAE_MODE_LSB]);
    endfunction : mode_of

    tae_mode_t mode;
    logic is_timer;
    logic is_event;
    logic tick_div1;
    logic tick_div8;
    logic tick_div32;
    logic src_tick;
    logic ev_tick;
    logic gate_ok;
    logic step;
    logic dir_up;
    logic wrap;

    // ==========================================================
    // count qualification
    always_comb begin
        mode = mode_of(cfg_in.mode_reg);
        is_timer = (mode == TAE_MODE_TIMER);
        is_event = (mode == TAE_MODE_EVENT);
        // internal count sources from the system clock prescaler
        tick_div1 = 1'b1;
        tick_div8 = (st_q.pre[2:0] == TAE_DIV8_LAST[2:0]);
        tick_div32 = (st_q.pre == TAE_DIV32_LAST);
        unique case (cfg_in.clk_sel)
            TAE_SRC_DIV1: src_tick = tick_div1;
            TAE_SRC_DIV8: src_tick = tick_div8;
            TAE_SRC_DIV32: src_tick = tick_div32;
            TAE_SRC_SUB32: src_tick = subclk_div32_in;
        endcase
        // event source: pin edge or another timer overflow
        unique case (cfg_in.ev_sel)
            TAE_EV_PIN: ev_tick = cfg_in.ev_falling ? in_fall : in_rise;
            TAE_EV_TIMER_TWO: ev_tick = ovf_in.input_timer_two;
            TAE_EV_TIMER_FIVE: ev_tick = ovf_in.input_timer_five;
            TAE_EV_NEIGHBOR_J: ev_tick = ovf_in.neighbor_timer_j;
            TAE_EV_NEIGHBOR_K: ev_tick = ovf_in.neighbor_timer_k;
            default: ev_tick = 1'b0;
        endcase
        // gate pauses counting while the input pin is inactive
        gate_ok = !cfg_in.gate_en || (in_level == cfg_in.gate_level);
        // direction: timer mode always down
        dir_up = cfg_in.dir_from_pin ? dir_level : cfg_in.dir_up_sw;
        if (is_timer) begin
            step = start_in && src_tick && gate_ok;
        end else if (is_event) begin
            step = start_in && ev_tick;
        end else begin
            step = 1'b0;
        end
        // terminal count: underflow going down, overflow going up
        if (is_event && dir_up) begin
            wrap = step && (st_q.cnt == TAE_CNT_MAX[WIDTH-1:0]);
        end else begin
            wrap = step && (st_q.cnt == TAE_CNT_MIN[WIDTH-1:0]);
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.pre = st_q.pre + 5'h01;
        st_d.irq = 1'b0;
        // software write to timer register
        if (wr_in.we) begin
            st_d.reload = wr_in.data[WIDTH-1:0];
        end
        // counting step
        if (step) begin
            if (wrap && !(is_event && cfg_in.free_run)) begin
                // reload takes the register, including a write pending now
                st_d.cnt = st_d.reload;
            end else if (is_event && dir_up) begin
                st_d.cnt = st_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
            end else begin
                st_d.cnt = st_q.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
        // a write while stopped goes to the counter too
        if (wr_in.we && !start_in) begin
            st_d.cnt = wr_in.data[WIDTH-1:0];
        end
        // interrupt and pulse output on every wrap
        if (wrap) begin
            st_d.irq = 1'b1;
            if (cfg_in.pulse_en) begin
                st_d.pout = ~st_q.pout;
            end
        end
        if (!cfg_in.pulse_en) begin
            st_d.pout = 1'b0;
        end
        // pin ownership
        st_d.in_busy = (is_timer && cfg_in.gate_en)
            || (is_event && cfg_in.ev_sel == TAE_EV_PIN);
        st_d.pin_oe = (is_timer || is_event) && cfg_in.pulse_en;
        st_d.out_busy = st_d.pin_oe || (is_event && cfg_in.dir_from_pin);
        st_d.cap = TAE_TWO_PHASE_MASK[CHANNEL];
        st_d.active = start_in && (is_timer || is_event);
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_out = st_q.cnt;
    assign reload_out = st_q.reload;
    assign irq_out = st_q.irq;
    assign timer_out_pin_out = st_q.pout;
    assign timer_out_pin_oe_out = st_q.pin_oe;
    assign in_pin_busy_out = st_q.in_busy;
    assign out_pin_busy_out = st_q.out_busy;
    assign two_phase_cap_out = st_q.cap;
    assign active_out = st_q.active;
endmodule : tae_timer
`default_nettype wire

// *** tb/tae_timer_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checker of one timer channel
module tae_timer_monitor
    import tae_pkg::*;
#(
    parameter int CHANNEL = 0,
    parameter int WIDTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire tae_pkg::tae_cfg_t cfg_in,
    input wire logic start_in,
    input wire tae_pkg::tae_wr_t wr_in,
    input wire logic subclk_div32_in,
    input wire tae_pkg::tae_ovf_t ovf_in,
    input wire logic timer_in_pin_in,
    input wire logic timer_out_pin_in,
    input wire logic [WIDTH-1:0] count_out,
    input wire logic [WIDTH-1:0] reload_out,
    input wire logic irq_out,
    input wire logic timer_out_pin_out,
    input wire logic timer_out_pin_oe_out,
    input wire logic in_pin_busy_out,
    input wire logic out_pin_busy_out,
    input wire logic two_phase_cap_out,
    input wire logic active_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic timer_m = cfg_in.mode_reg[1:0] == 2'h0; // timer mode selected

    stop_write_a: assert property (
        wr_in.we && !start_in |=> count_out == $past(wr_in.data) && reload_out == count_out)
        else $error("stopped write not loaded");
    reload_write_a: assert property (
        wr_in.we |=> reload_out == $past(wr_in.data)) else $error("reload not written");
    halt_hold_a: assert property (
        !start_in && !wr_in.we |=> $stable(count_out)) else $error("count moved while halted");
    down_step_a: assert property (
        timer_m && $changed(count_out) && !$past(wr_in.we) && !irq_out
        |-> count_out == $past(count_out) - 16'h0001) else $error("timer step not minus one");
    wrap_reload_a: assert property (
        irq_out && !cfg_in.free_run |-> count_out == reload_out) else $error("wrap without reload");
    under_irq_a: assert property (
        irq_out && timer_m |-> $past(count_out) == 16'h0000) else $error("irq not at underflow");
    pulse_flip_a: assert property (
        cfg_in.pulse_en && $past(cfg_in.pulse_en)
        |-> (timer_out_pin_out != $past(timer_out_pin_out)) == irq_out) else $error("pin flip bad");
    out_owner_a: assert property (
        1'b1 |=> timer_out_pin_oe_out == $past(cfg_in.pulse_en && !cfg_in.mode_reg[1]))
        else $error("out pin enable wrong");
    cap_fixed_a: assert property (
        1'b1 |=> two_phase_cap_out == TAE_TWO_PHASE_MASK[CHANNEL]) else $error("two-phase flag");
    in_owner_a: assert property (
        1'b1 |=> in_pin_busy_out == $past((cfg_in.mode_reg[1:0] == 2'h0 && cfg_in.gate_en)
        || (cfg_in.mode_reg[1:0] == 2'h1 && cfg_in.ev_sel == TAE_EV_PIN)))
        else $error("in pin ownership wrong");
    out_busy_a: assert property (
        1'b1 |=> out_pin_busy_out == $past(!cfg_in.mode_reg[1] && (cfg_in.pulse_en
        || (cfg_in.mode_reg[0] && cfg_in.dir_from_pin)))) else $error("out pin ownership wrong");
    run_flag_a: assert property (
        1'b1 |=> active_out == $past(start_in && !cfg_in.mode_reg[1])) else $error("run flag wrong");

    // main scenarios reached
    cover property (irq_out && timer_m);
    cover property (irq_out && !timer_m && cfg_in.free_run);
    cover property (wr_in.we && start_in);
endmodule : tae_timer_monitor

bind tae_timer tae_timer_monitor #(.CHANNEL(CHANNEL), .WIDTH(WIDTH)) tae_timer_monitor_i (.*);
`default_nettype wire

// *** tb/tae_pin_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// far-side driver of count, gate and direction pin levels
module tae_pin_model (
    input wire logic clk_in,
    input wire logic go_in,          // start a burst of pulses
    input wire logic [3:0] num_in,   // pulses in a burst
    input wire logic [1:0] gap_in,   // extra cycles per half pulse
    input wire logic gate_mode_in,   // in pin carries the gate level
    input wire logic gate_on_in,
    input wire logic dir_up_in,
    output logic in_pin_out,
    output logic dir_pin_out,
    output logic busy_out
);
    logic [4:0] half_q = 5'h00; // half pulses still to send
    logic [1:0] wait_q = 2'h0;  // slow-down count
    logic lvl_q = 1'b0;         // pulse level, idles low
    // pulse burst generator
    always @(posedge clk_in) begin
        if (go_in && half_q == 5'h00) begin
            half_q <= {num_in, 1'b0};
            wait_q <= gap_in;
        end else if (half_q != 5'h00) begin
            if (wait_q == 2'h0) begin
                lvl_q <= !lvl_q;
                half_q <= half_q - 5'h01;
                wait_q <= gap_in;
            end else
                wait_q <= wait_q - 2'h1;
        end
    end
    assign in_pin_out = gate_mode_in ? gate_on_in : lvl_q;
    assign dir_pin_out = dir_up_in;
    assign busy_out = half_q != 5'h00;
endmodule : tae_pin_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, exp, got); end end
// ==========================================================
// top bench of one timer channel
module tb;
    import tae_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0, sub_tick = 1'b0;
    tae_cfg_t cfg = '0;
    tae_wr_t wr = '0;
    tae_ovf_t ovf = '0;
    logic [15:0] count, reload, r;
    logic irq, pin_out, in_pin, dir_pin, m_busy, go = 1'b0, gmode = 1'b0, gon = 1'b0, dup = 1'b1;
    logic [3:0] num = 4'h0;
    logic [1:0] gap = 2'h0;
    int fail_count = 0, check_count = 0, cycles = 0, irqs = 0, p, w, seed = 32'hdfb5;

    tae_timer #(.CHANNEL(3)) tae_timer_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg), .start_in(start_in), .wr_in(wr),
        .subclk_div32_in(sub_tick), .ovf_in(ovf), .timer_in_pin_in(in_pin),
        .timer_out_pin_in(dir_pin), .count_out(count), .reload_out(reload), .irq_out(irq),
        .timer_out_pin_out(pin_out), .timer_out_pin_oe_out(), .in_pin_busy_out(),
        .out_pin_busy_out(), .two_phase_cap_out(), .active_out());
    tae_pin_model tae_pin_model_i (
        .clk_in(clk_in), .go_in(go), .num_in(num), .gap_in(gap), .gate_mode_in(gmode),
        .gate_on_in(gon), .dir_up_in(dup), .in_pin_out(in_pin), .dir_pin_out(dir_pin),
        .busy_out(m_busy));

    initial forever #5 clk_in = ~clk_in;
    // cycle count, hang limit, irq tally and a subclock tick every fourth cycle
    always @(posedge clk_in) begin
        cycles++;
        if (irq === 1'b1) irqs++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end
    always @(negedge clk_in) sub_tick <= (cycles % 4 == 0);

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick
    task automatic write(input logic [15:0] v);
        wr = '{we: 1'b1, data: v};
        tick(1);
        wr = '0;
    endtask : write
    task automatic strobe(input logic [3:0] m);
        ovf = tae_ovf_t'(m);
        tick(1);
        ovf = '0;
        tick(1);
    endtask : strobe
    // cycles from just after one irq pulse to the next
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            tick(1);
            n++;
        end
        tick(1);
    endtask : wait_irq
    function automatic int mult(input int s);
        return s == 0 ? 1 : s == 1 ? 8 : s == 2 ? 32 : 4;
    endfunction : mult
    // expected count after e events, w gets the number of wraps
    function automatic logic [15:0] ev_exp(input logic [15:0] n, input int e, input bit up,
        input bit fr, output int w);
        logic [15:0] c;
        logic wrap;
        c = n;
        w = 0;
        repeat (e) begin
            wrap = c == (up ? 16'hFFFF : 16'h0000);
            w += wrap;
            c = (wrap && !fr) ? n : (up ? c + 16'h0001 : c - 16'h0001);
        end
        return c;
    endfunction : ev_exp
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    initial begin
        tick(2);
        rst_n_in = 1'b1;
        `CHK("reset count", 16'h0000, count)
        // timer mode over every clock source, with a write while running
        for (int s = 0; s < 4; s++) begin
            start_in = 1'b0;
            cfg = '0;
            cfg.clk_sel = tae_clk_sel_t'(s);
            cfg.pulse_en = 1'($random(seed));
            r = 16'h0002 + 16'($random(seed) & 7);
            write(r);
            `CHK("stopped load", r, count)
            start_in = 1'b1;
            wait_irq(p);
            wait_irq(p);
            `CHK("period", mult(s) * (r + 1) - 1, p)
            r = 16'h0001 + 16'($random(seed) & 7);
            write(r);
            `CHK("reload", r, reload)
            wait_irq(p);
            wait_irq(p);
            `CHK("new period", mult(s) * (r + 1) - 1, p)
        end
        // gate level pauses and releases counting
        start_in = 1'b0;
        cfg = '0;
        cfg.gate_en = 1'b1;
        cfg.gate_level = 1'b1;
        gmode = 1'b1;
        write(16'h0100);
        start_in = 1'b1;
        tick(8);
        `CHK("gate closed", 16'h0100, count)
        gon = 1'b1;
        tick(8);
        `CHK("gate open", 1'b1, count < 16'h0100)
        // closing the gate freezes the count and leaves the pin low before the event runs
        gon = 1'b0;
        tick(3);
        r = count;
        tick(4);
        `CHK("gate shut", r, count)
        gmode = 1'b0;
        // pin events up and down, reload and free-run, around the wrap point
        for (int k = 0; k < 4; k++) begin
            start_in = 1'b0;
            cfg = '0;
            cfg.mode_reg = 8'h01;
            cfg.ev_falling = 1'($random(seed));
            cfg.dir_from_pin = 1'($random(seed));
            cfg.dir_up_sw = k[0];
            cfg.free_run = k[1];
            cfg.pulse_en = 1'b1;
            dup = k[0];
            r = k[0] ? 16'hFFFD : 16'h0002;
            write(r);
            irqs = 0;
            start_in = 1'b1;
            num = 4'h5 + 4'($random(seed) & 3);
            gap = 2'($random(seed));
            go = 1'b1;
            tick(1);
            go = 1'b0;
            tick(1);
            while (m_busy === 1'b1) tick(1);
            tick(6);
            `CHK("events", ev_exp(r, num, k[0], k[1], w), count)
            `CHK("wraps", w, irqs)
        end
        // overflow strobes of other timers, one selected at a time
        for (int s = 1; s < 5; s++) begin
            start_in = 1'b0;
            cfg.ev_sel = tae_ev_sel_t'(s);
            cfg.dir_up_sw = 1'b1;
            cfg.dir_from_pin = 1'b0;
            write(16'h0000);
            start_in = 1'b1;
            repeat (3) strobe(4'(8 >> (s - 1)));
            strobe(~4'(8 >> (s - 1)));
            tick(3);
            `CHK("timer events", 16'h0003, count)
        end
        // the other modes never count
        for (int m = 2; m < 4; m++) begin
            start_in = 1'b0;
            cfg.mode_reg = 8'(m);
            write(16'h0005);
            start_in = 1'b1;
            strobe(4'hF);
            tick(4);
            `CHK("idle mode", 16'h0005, count)
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
